// *** hw/rre_exec.sv ***
// Return and rotate-left execution logic of the 8-bit core
`timescale 1ns/1ns

module rre_exec #(
    parameter int DATA_W = rre_pkg::DATA_W,
    parameter int PC_W = rre_pkg::PC_W
) (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire rre_pkg::rre_req_t REQ,
    input wire logic [PC_W-1:0] STACK_TOP,
    input wire logic IRQ_PENDING,
    input wire logic [PC_W-1:0] IRQ_VECTOR,
    input wire logic GIE_CLEAR,
    input wire logic [3:0] FLAGS_IN,
    output rre_pkg::rre_res_t RES,
    output logic [DATA_W-1:0] ACC,
    output logic [PC_W-1:0] FETCH_PC,
    output logic GLOBAL_INTERRUPT_ENABLE,
    output logic [3:0] FLAGS_OUT
);

    // ******************************************************
    // Helpers
    // ******************************************************

    // One-bit left rotation, top bit wraps to bit zero
    function automatic logic [DATA_W-1:0] rot_left(
        input logic [DATA_W-1:0] v
    );
        rot_left = {v[DATA_W-2:0], v[DATA_W-1]};
    endfunction

    logic [DATA_W-1:0] acc_q, acc_d;
    logic [PC_W-1:0] pc_q, pc_d;
    logic gie_q, gie_d;
    logic [3:0] flags_q, flags_d;
    rre_pkg::rre_res_t res_q, res_d;
    logic [DATA_W-1:0] rot;

    // ******************************************************
    // Next-state computation
    // ******************************************************

    // Decode the issued operation into core state updates
    always_comb begin
        rot = rot_left(REQ.mem_rdata);
        acc_d = acc_q;
        pc_d = pc_q;
        gie_d = gie_q;
        flags_d = FLAGS_IN;
        res_d = '0;
        if (GIE_CLEAR) begin
            gie_d = 1'b0;
        end
        if (REQ.valid) begin
            unique case (REQ.op)
                rre_pkg::OP_SUB_EXIT: begin
                    pc_d = STACK_TOP;
                    res_d.stack_pop = 1'b1;
                end
                rre_pkg::OP_SUB_EXIT_IMM: begin
                    pc_d = STACK_TOP;
                    res_d.stack_pop = 1'b1;
                    acc_d = REQ.imm;
                    res_d.acc_we = 1'b1;
                end
                rre_pkg::OP_INT_EXIT: begin
                    res_d.stack_pop = 1'b1;
                    gie_d = 1'b1;
                    if (IRQ_PENDING) begin
                        pc_d = IRQ_VECTOR;
                        res_d.irq_take = 1'b1;
                        gie_d = 1'b0;
                    end else begin
                        pc_d = STACK_TOP;
                    end
                end
                rre_pkg::OP_ROT_MEM: begin
                    res_d.mem_we = 1'b1;
                    res_d.mem_wdata = rot;
                end
                rre_pkg::OP_ROT_ACC: begin
                    acc_d = rot;
                    res_d.acc_we = 1'b1;
                end
                default: begin
                end
            endcase
        end
        res_d.pc_load = res_d.stack_pop;
        res_d.pc_value = pc_d;
        res_d.acc_value = acc_d;
    end

    // ******************************************************
    // State registers
    // ******************************************************

    // Register core state and result bundle
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            acc_q <= rre_pkg::ACC_RST;
            pc_q <= rre_pkg::PC_RST;
            gie_q <= 1'b0;
            flags_q <= '0;
            res_q <= '0;
        end else begin
            acc_q <= acc_d;
            pc_q <= pc_d;
            gie_q <= gie_d;
            flags_q <= flags_d;
            res_q <= res_d;
        end
    end

    assign RES = res_q;
    assign ACC = acc_q;
    assign FETCH_PC = pc_q;
    assign GLOBAL_INTERRUPT_ENABLE = gie_q;
    assign FLAGS_OUT = flags_q;

    // ******************************************************
    // Checks
    // ******************************************************

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);

    sequence exit_plain_s;
        REQ.valid && REQ.op inside {rre_pkg::OP_SUB_EXIT,
            rre_pkg::OP_SUB_EXIT_IMM};
    endsequence

    sequence int_exit_s;
        REQ.valid && REQ.op == rre_pkg::OP_INT_EXIT;
    endsequence

    sequence rot_any_s;
        REQ.valid && REQ.op inside {rre_pkg::OP_ROT_MEM,
            rre_pkg::OP_ROT_ACC};
    endsequence

    sub_exit_pc_a: assert property (
        exit_plain_s |=> FETCH_PC == $past(STACK_TOP) && RES.pc_load)
        else $error("exit did not restore pc");
    imm_acc_a: assert property (
        REQ.valid && REQ.op == rre_pkg::OP_SUB_EXIT_IMM
        |=> ACC == $past(REQ.imm) && RES.acc_we)
        else $error("immediate not loaded");
    int_exit_gie_a: assert property (
        int_exit_s and !IRQ_PENDING
        |=> GLOBAL_INTERRUPT_ENABLE && FETCH_PC == $past(STACK_TOP))
        else $error("interrupt exit wrong");
    pending_irq_a: assert property (
        int_exit_s and IRQ_PENDING
        |=> RES.irq_take && FETCH_PC == $past(IRQ_VECTOR))
        else $error("pending interrupt missed");
    rot_mem_a: assert property (
        REQ.valid && REQ.op == rre_pkg::OP_ROT_MEM
        |=> RES.mem_we && RES.mem_wdata ==
            {$past(REQ.mem_rdata[DATA_W-2:0]),
             $past(REQ.mem_rdata[DATA_W-1])})
        else $error("memory rotate wrong");
    rot_acc_a: assert property (
        REQ.valid && REQ.op == rre_pkg::OP_ROT_ACC
        |=> !RES.mem_we && ACC ==
            {$past(REQ.mem_rdata[DATA_W-2:0]),
             $past(REQ.mem_rdata[DATA_W-1])})
        else $error("accumulator rotate wrong");
    flags_keep_a: assert property (
        REQ.valid |=> FLAGS_OUT == $past(FLAGS_IN))
        else $error("flags altered");
    idle_quiet_a: assert property (
        !REQ.valid |=> !RES.mem_we && !RES.pc_load && !RES.acc_we)
        else $error("spurious write");
    // Result bundle carries the restored address
    exit_pc_value_a: assert property (
        exit_plain_s |=> RES.pc_value == $past(STACK_TOP) && RES.stack_pop)
        else $error("exit address not reported");
    // Plain exit leaves the accumulator alone
    sub_exit_acc_a: assert property (
        REQ.valid && REQ.op == rre_pkg::OP_SUB_EXIT
        |=> $stable(ACC) && !RES.acc_we && !RES.mem_we)
        else $error("plain exit touched data");
    // Immediate also reported in the result bundle
    imm_res_a: assert property (
        REQ.valid && REQ.op == rre_pkg::OP_SUB_EXIT_IMM
        |=> RES.acc_value == $past(REQ.imm) && FETCH_PC == $past(STACK_TOP))
        else $error("immediate exit result wrong");
    // Clear drops global enable when no exit competes
    gie_clear_a: assert property (
        GIE_CLEAR && !(REQ.valid && REQ.op == rre_pkg::OP_INT_EXIT)
        |=> !GLOBAL_INTERRUPT_ENABLE)
        else $error("global enable not cleared");
    // Exit setting the enable wins over a clear
    int_exit_wins_a: assert property (
        int_exit_s and GIE_CLEAR and !IRQ_PENDING
        |=> GLOBAL_INTERRUPT_ENABLE && RES.stack_pop)
        else $error("clear beat interrupt exit");
    // Pending service keeps the enable low, pops once
    irq_gie_low_a: assert property (
        int_exit_s and IRQ_PENDING
        |=> !GLOBAL_INTERRUPT_ENABLE && RES.stack_pop && RES.pc_load)
        else $error("pending entry left enable set");
    // Rotates never move the program counter
    rot_pc_keep_a: assert property (
        rot_any_s |=> $stable(FETCH_PC) && !RES.pc_load && !RES.stack_pop)
        else $error("rotate moved pc");
    // Memory rotate leaves the accumulator alone
    rot_mem_acc_a: assert property (
        REQ.valid && REQ.op == rre_pkg::OP_ROT_MEM
        |=> $stable(ACC) && !RES.acc_we)
        else $error("memory rotate hit accumulator");
    // Idle cycles hold program counter and accumulator
    idle_hold_a: assert property (
        !REQ.valid |=> $stable(FETCH_PC) && $stable(ACC))
        else $error("state moved while idle");

endmodule // rre_exec

// *** hw/rre_pkg.sv ***
// Package: operation codes, widths and carrier structs for the exec block
package rre_pkg;
    localparam int DATA_W = 8;
    localparam int PC_W = 13;
    localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
    localparam logic [PC_W-1:0] PC_RST = 13'h0000;
    localparam int MSB = DATA_W - 1;

    // Operation selector handed over by the instruction decoder
    typedef enum logic [2:0] {
        OP_NONE,
        OP_SUB_EXIT,
        OP_SUB_EXIT_IMM,
        OP_INT_EXIT,
        OP_ROT_MEM,
        OP_ROT_ACC
    } rre_op_t;

    // Issue request from the decoder
    typedef struct packed {
        logic valid;
        rre_op_t op;
        logic [DATA_W-1:0] imm;
        logic [DATA_W-1:0] mem_rdata;
    } rre_req_t;

    // Result bundle towards core state
    typedef struct packed {
        logic pc_load;
        logic [PC_W-1:0] pc_value;
        logic stack_pop;
        logic acc_we;
        logic [DATA_W-1:0] acc_value;
        logic mem_we;
        logic [DATA_W-1:0] mem_wdata;
        logic irq_take;
    } rre_res_t;
endpackage

// *** testbench/rre_exec_tb_top.sv ***
// Testbench for the return and rotate-left execution block
`timescale 1ns/1ns
module rre_exec_tb_top;
    logic clk, rst_n, irq, gclr;
    rre_pkg::rre_req_t req;
    logic [12:0] top, vec, pc;
    logic [3:0] fl, flo;
    rre_pkg::rre_res_t res;
    logic [7:0] acc;
    logic gie;
    int err_count = 0;
    int compares = 0;

    rre_exec rre_exec_inst (.CORE_CLK(clk), .RESET_N(rst_n), .REQ(req),
        .STACK_TOP(top), .IRQ_PENDING(irq), .IRQ_VECTOR(vec),
        .GIE_CLEAR(gclr), .FLAGS_IN(fl), .RES(res), .ACC(acc),
        .FETCH_PC(pc), .GLOBAL_INTERRUPT_ENABLE(gie), .FLAGS_OUT(flo));

    // ****************
    // Helpers
    // ****************
    // Compare one value
    task chk(input logic [12:0] got, input logic [12:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Issue one request, valid left high for back-to-back use
    task issue(input rre_pkg::rre_op_t op, input logic [7:0] imm,
               input logic [7:0] md);
        req = '{1'b1, op, imm, md};
        @(posedge clk);
        #1;
    endtask

    // Drop valid and let one edge pass
    task idle;
        req.valid = 1'b0;
        @(posedge clk);
        #1;
    endtask

    // Clear global enable as interrupt entry would
    task gie_off;
        gclr = 1'b1;
        @(posedge clk);
        #1;
        gclr = 1'b0;
    endtask

    // ****************
    // Scenarios
    // ****************
    // subroutine exit
    task t_sub;
        top = 13'h1abc;
        fl = 4'ha;
        issue(rre_pkg::OP_SUB_EXIT, 8'h00, 8'h00);
        chk(pc, 13'h1abc);
        chk({11'h0, res.pc_load, res.stack_pop}, 13'h0003);
        chk(res.pc_value, 13'h1abc);
        chk({12'h0, res.acc_we}, 13'h0000);
        chk({9'h0, flo}, 13'h000a);
        idle;
    endtask

    task t_imm;
        top = 13'h0123;
        issue(rre_pkg::OP_SUB_EXIT_IMM, 8'hc3, 8'h00);
        chk(pc, 13'h0123);
        chk({5'h0, acc}, 13'h00c3);
        chk({4'h0, res.acc_we, res.acc_value}, 13'h01c3);
        idle;
    endtask

    task t_interrupt_exit;
        gie_off;
        chk({12'h0, gie}, 13'h0000);
        top = 13'h0456;
        issue(rre_pkg::OP_INT_EXIT, 8'h00, 8'h00);
        chk(pc, 13'h0456);
        chk({12'h0, gie}, 13'h0001);
        idle;
    endtask

    task t_interrupt_exit_irq;
        gie_off;
        chk({12'h0, gie}, 13'h0000);
        irq = 1'b1;
        vec = 13'h0004;
        issue(rre_pkg::OP_INT_EXIT, 8'h00, 8'h00);
        chk(pc, 13'h0004);
        chk(res.pc_value, 13'h0004);
        chk({12'h0, gie}, 13'h0000);
        chk({11'h0, res.irq_take, res.stack_pop}, 13'h0003);
        irq = 1'b0;
        idle;
    endtask

    // interrupt exit wins over a clear in one cycle
    task t_interrupt_exit_clr;
        top = 13'h0789;
        gclr = 1'b1;
        issue(rre_pkg::OP_INT_EXIT, 8'h00, 8'h00);
        gclr = 1'b0;
        chk({12'h0, gie}, 13'h0001);
        chk(pc, 13'h0789);
        idle;
    endtask

    task t_rot;
        fl = 4'h5;
        issue(rre_pkg::OP_ROT_MEM, 8'h00, 8'h81);
        chk({4'h0, res.mem_we, res.mem_wdata}, 13'h0103);
        chk({12'h0, res.acc_we}, 13'h0000);
        chk({5'h0, acc}, 13'h00c3);
        chk(pc, 13'h0789);
        issue(rre_pkg::OP_ROT_ACC, 8'h00, 8'h4e);
        chk({12'h0, res.mem_we}, 13'h0000);
        chk({5'h0, acc}, 13'h009c);
        chk({4'h0, res.acc_we, res.acc_value}, 13'h019c);
        chk({9'h0, flo}, 13'h0005);
        idle;
        chk({11'h0, res.acc_we, res.mem_we}, 13'h0000);
    endtask

    // Mid-run reset clears state, then a request is taken
    task t_reset;
        rst_n = 1'b0;
        @(posedge clk);
        #1;
        chk(pc, 13'h0000);
        chk({5'h0, acc}, 13'h0000);
        chk({8'h0, gie, flo}, 13'h0000);
        rst_n = 1'b1;
        idle;
        chk(pc, 13'h0000);
        top = 13'h0a5a;
        issue(rre_pkg::OP_SUB_EXIT, 8'h00, 8'h00);
        chk(pc, 13'h0a5a);
        idle;
    endtask

    // Print counts and verdict, then stop
    task complete_run;
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Clock source
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Main sequence
    initial begin
        rst_n = 1'b0;
        irq = 1'b0;
        gclr = 1'b0;
        req = '0;
        top = 13'h0000;
        vec = 13'h0000;
        fl = 4'h0;
        repeat (10) @(posedge clk);
        #1;
        rst_n = 1'b1;
        t_sub;
        t_imm;
        t_interrupt_exit;
        t_interrupt_exit_irq;
        t_interrupt_exit_clr;
        t_rot;
        t_reset;
        complete_run;
    end
endmodule // rre_exec_tb_top
